// ===== bench/peripheral_multiply_accumulate_test.sv
`timescale 1ns/1ps
`default_nettype none

module peripheral_multiply_accumulate_test
	import pmac_pkg::*;
;
	typedef struct packed {
		logic [8:0] mode_addr;
		logic byte_acc;
		logic [15:0] op1, op2, seed_hi, seed_lo, lo, hi, ext;
	} pmac_row_s;

	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	pmac_req_s bus_req;
	logic [15:0] rdata;
	logic rvalid;
	logic [15:0] q;
	logic ok;
	logic busy;
	int error_cnt = 0;
	int total_checks = 0;

	always #12.5 mclk = ~mclk;

	pmac_core pmac_core_inst (.mclk(mclk), .reset_n(reset_n), .bus_req(bus_req), .rdata(rdata), .rvalid(rvalid),
		.busy(busy));
	pmac_cpu_model pmac_cpu_model_inst (.mclk(mclk), .rdata(rdata), .rvalid(rvalid), .bus_req(bus_req));

	// Seeds preload the accumulator so carry and overflow cases need only one product.
	localparam pmac_row_s ROWS [6] = '{
		'{PMAC_ADDR_OP1_UMUL, 1'b0, 16'h1234, 16'h5678, 16'h0000, 16'h0000, 16'h0060, 16'h0626, 16'h0000},
		'{PMAC_ADDR_OP1_SMUL, 1'b0, 16'hFFFF, 16'h0002, 16'h0000, 16'h0000, 16'hFFFE, 16'hFFFF, 16'hFFFF},
		'{PMAC_ADDR_OP1_UACC, 1'b0, 16'h0001, 16'h0001, 16'hFFFF, 16'hFFFF, 16'h0000, 16'h0000, 16'h0001},
		'{PMAC_ADDR_OP1_SACC, 1'b0, 16'h0001, 16'h0001, 16'h7FFF, 16'hFFFF, 16'h0000, 16'h8000, 16'hFFFF},
		'{PMAC_ADDR_OP1_SMUL, 1'b1, 16'h0080, 16'h0002, 16'h0000, 16'h0000, 16'hFF00, 16'hFFFF, 16'hFFFF},
		'{PMAC_ADDR_OP1_UMUL, 1'b1, 16'h0080, 16'h0002, 16'h0000, 16'h0000, 16'h0100, 16'h0000, 16'h0000}
	};

	task automatic results();
		if (error_cnt == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : results

	task automatic wr(input logic [8:0] a, input logic [15:0] d, input logic b);
		pmac_cpu_model_inst.acc(1'b1, b, a, d);
	endtask : wr

	// A missing answer pulse ends the run at once.
	task automatic rd_check(input logic [8:0] a, input logic [15:0] exp);
		pmac_cpu_model_inst.rd(a, q, ok);
		total_checks++;
		if (ok !== 1'b1 || q !== exp) begin
			error_cnt++;
			$display("BAD %0t read %h gave %h want %h", $time, a, q, exp);
		end
		if (ok !== 1'b1) begin
			results();
		end
	endtask : rd_check

	// Busy is looked at on the falling edge right after the write, while its one-cycle pulse stands.
	task automatic busy_check(input logic exp);
		total_checks++;
		if (busy !== exp) begin
			error_cnt++;
			$display("BAD %0t busy %b want %b", $time, busy, exp);
		end
	endtask : busy_check

	initial begin
		repeat (12) @(posedge mclk);
		@(negedge mclk);
		reset_n = 1'b1;
		foreach (ROWS[i]) begin
			wr(PMAC_ADDR_RESULT_HIGH_WORD, ROWS[i].seed_hi, 1'b0);
			wr(PMAC_ADDR_RESULT_LOW_WORD, ROWS[i].seed_lo, 1'b0);
			wr(ROWS[i].mode_addr, ROWS[i].op1, ROWS[i].byte_acc);
			wr(PMAC_ADDR_OP2, ROWS[i].op2, ROWS[i].byte_acc);
			rd_check(PMAC_ADDR_RESULT_LOW_WORD, ROWS[i].lo);
			rd_check(PMAC_ADDR_RESULT_HIGH_WORD, ROWS[i].hi);
			rd_check(PMAC_ADDR_SUM_EXTENSION_WORD, ROWS[i].ext);
		end
		// Operand one and its mode stay; a second operand alone reruns the product.
		wr(PMAC_ADDR_OP2, 16'h0003, 1'b0);
		busy_check(1'b1);
		rd_check(PMAC_ADDR_RESULT_LOW_WORD, 16'h0180);
		busy_check(1'b0);
		rd_check(PMAC_ADDR_OP1_UMUL, 16'h0080);
		wr(PMAC_ADDR_OP1_SACC, 16'h0010, 1'b0);
		rd_check(PMAC_ADDR_RESULT_LOW_WORD, 16'h0180);
		// Two launches in a row accumulate onto each other, the second with a negative operand.
		wr(PMAC_ADDR_OP2, 16'h0010, 1'b0);
		wr(PMAC_ADDR_OP2, 16'hFFFF, 1'b0);
		rd_check(PMAC_ADDR_RESULT_LOW_WORD, 16'h0270);
		rd_check(PMAC_ADDR_RESULT_HIGH_WORD, 16'h0000);
		wr(PMAC_ADDR_SUM_EXTENSION_WORD, 16'h1234, 1'b0);
		rd_check(PMAC_ADDR_SUM_EXTENSION_WORD, 16'h0000);
		rd_check(9'h100, 16'h0000);
		// A reset in mid-run clears the results again.
		@(negedge mclk);
		reset_n = 1'b0;
		repeat (2) @(negedge mclk);
		reset_n = 1'b1;
		rd_check(PMAC_ADDR_RESULT_LOW_WORD, 16'h0000);
		results();
	end
endmodule : peripheral_multiply_accumulate_test

`default_nettype wire

// ===== bench/pmac_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none

// Processor side of the peripheral bus: one access per call, moved on falling edges.
module pmac_cpu_model
	import pmac_pkg::*;
(
	input wire logic mclk,
	input wire logic [15:0] rdata,
	input wire logic rvalid,
	output var pmac_req_s bus_req
);
	initial bus_req = '0;

	// Each call opens on a fresh falling edge, so a result read lands two edges after operand two.
	// Operand one and operand two of one operation can be split by other traffic; the bench puts a read between them.
	task automatic acc(input logic w, input logic b, input logic [8:0] a, input logic [15:0] d);
		@(negedge mclk);
		bus_req <= '{wr: w, rd: !w, byte_acc: b, addr: a, wdata: d};
		@(negedge mclk);
		// Released lines show inverted values so nothing relies on stale data.
		bus_req <= '{wr: 1'b0, rd: 1'b0, byte_acc: !b, addr: ~a, wdata: ~d};
	endtask : acc

	// The answer pulse stands for the cycle after the read edge, so it is looked at here.
	task automatic rd(input logic [8:0] a, output logic [15:0] q, output logic ok);
		acc(1'b0, 1'b0, a, 16'h0000);
		ok = rvalid;
		q = rdata;
	endtask : rd
endmodule : pmac_cpu_model

`default_nettype wire

// ===== hw/pmac_core.sv
`timescale 1ns/1ps
`default_nettype none

module pmac_core
	import pmac_pkg::*;
(
	input wire logic mclk,
	input wire logic reset_n,
	input wire pmac_req_s bus_req,
	output logic [15:0] rdata,
	output logic rvalid,
	output logic busy
);

	logic [15:0] op1_q;
	logic [15:0] op2_q;
	pmac_mode_e mode_q;
	logic [15:0] result_low_word_q;
	logic [15:0] result_high_word_q;
	logic [15:0] sum_extension_word_q;
	logic start_q;
	logic signed_sel;
	logic [15:0] wdata_ext;
	logic [32:0] prod;
	logic [32:0] acc_sum;
	logic signed_mode;
	logic wr_op1;
	logic wr_op2;
	pmac_mode_e wr_mode;

	// A byte write in a signed mode is widened with its sign; word writes pass through.
	assign signed_mode = (mode_q == PMAC_SMUL) || (mode_q == PMAC_SACC);
	assign signed_sel = wr_op1 ? (wr_mode == PMAC_SMUL || wr_mode == PMAC_SACC) : signed_mode;
	always_comb begin
		if (bus_req.byte_acc) begin
			wdata_ext = {{8{signed_sel & bus_req.wdata[PMAC_BYTE_SIGN]}}, bus_req.wdata[7:0]};
		end else begin
			wdata_ext = bus_req.wdata;
		end
	end

	// Address decode of the four operand-one aliases and the trigger register.
	always_comb begin
		wr_op1 = 1'b0;
		wr_mode = mode_q;
		if (bus_req.wr) begin
			unique case (bus_req.addr)
				PMAC_ADDR_OP1_UMUL: begin
					wr_op1 = 1'b1;
					wr_mode = PMAC_UMUL;
				end
				PMAC_ADDR_OP1_SMUL: begin
					wr_op1 = 1'b1;
					wr_mode = PMAC_SMUL;
				end
				PMAC_ADDR_OP1_UACC: begin
					wr_op1 = 1'b1;
					wr_mode = PMAC_UACC;
				end
				PMAC_ADDR_OP1_SACC: begin
					wr_op1 = 1'b1;
					wr_mode = PMAC_SACC;
				end
				default: begin
					wr_op1 = 1'b0;
				end
			endcase
		end
	end
	assign wr_op2 = bus_req.wr && (bus_req.addr == PMAC_ADDR_OP2);

	// Operand one and its mode persist until software rewrites them.
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			op1_q <= PMAC_RESET_WORD;
			mode_q <= PMAC_UMUL;
		end else if (wr_op1) begin
			op1_q <= wdata_ext;
			mode_q <= wr_mode;
		end
	end

	// Operand two is stored and raises a one-cycle start; operand one never does.
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			op2_q <= PMAC_RESET_WORD;
			start_q <= 1'b0;
		end else begin
			start_q <= wr_op2;
			if (wr_op2) begin
				op2_q <= wdata_ext;
			end
		end
	end

	// The product is formed in one cycle so the result settles well inside the budget.
	always_comb begin
		if (signed_mode) begin
			prod = {{1{1'b0}}, 32'($signed(op1_q) * $signed(op2_q))};
		end else begin
			prod = {1'b0, 32'(op1_q * op2_q)};
		end
		acc_sum = {1'b0, result_high_word_q, result_low_word_q} + {1'b0, prod[31:0]};
	end

	// Result update; the signed-multiply high word already has the sign in its top bit.
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			result_low_word_q <= PMAC_RESET_WORD;
			result_high_word_q <= PMAC_RESET_WORD;
			sum_extension_word_q <= PMAC_RESET_WORD;
		end else if (start_q) begin
			unique case (mode_q)
				PMAC_UMUL: begin
					result_low_word_q <= prod[15:0];
					result_high_word_q <= prod[31:16];
					sum_extension_word_q <= PMAC_RESET_WORD;
				end
				PMAC_SMUL: begin
					result_low_word_q <= prod[15:0];
					result_high_word_q <= prod[31:16];
					sum_extension_word_q <= prod[31] ? PMAC_ALL_ONES : PMAC_RESET_WORD;
				end
				PMAC_UACC: begin
					result_low_word_q <= acc_sum[15:0];
					result_high_word_q <= acc_sum[31:16];
					sum_extension_word_q <= acc_sum[32] ? PMAC_CARRY_ONE : PMAC_RESET_WORD;
				end
				PMAC_SACC: begin
					result_low_word_q <= acc_sum[15:0];
					result_high_word_q <= acc_sum[31:16];
					sum_extension_word_q <= acc_sum[31] ? PMAC_ALL_ONES : PMAC_RESET_WORD;
				end
			endcase
		end else if (bus_req.wr && bus_req.addr == PMAC_ADDR_RESULT_LOW_WORD) begin
			result_low_word_q <= wdata_ext;
		end else if (bus_req.wr && bus_req.addr == PMAC_ADDR_RESULT_HIGH_WORD) begin
			result_high_word_q <= wdata_ext;
		end
	end

	// Read port: registered data one cycle after the read, with no side effects.
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			rdata <= PMAC_RESET_WORD;
			rvalid <= 1'b0;
		end else begin
			rvalid <= bus_req.rd;
			if (bus_req.rd) begin
				unique case (bus_req.addr)
					PMAC_ADDR_OP1_UMUL, PMAC_ADDR_OP1_SMUL,
					PMAC_ADDR_OP1_UACC, PMAC_ADDR_OP1_SACC: rdata <= op1_q;
					PMAC_ADDR_OP2: rdata <= op2_q;
					PMAC_ADDR_RESULT_LOW_WORD: rdata <= result_low_word_q;
					PMAC_ADDR_RESULT_HIGH_WORD: rdata <= result_high_word_q;
					PMAC_ADDR_SUM_EXTENSION_WORD: rdata <= sum_extension_word_q;
					default: rdata <= PMAC_RESET_WORD;
				endcase
			end
		end
	end

	// Reads answer one cycle later with the addressed register and disturb nothing.
	a_read_pulse: assert property (@(posedge mclk) disable iff (!reset_n)
		bus_req.rd |=> rvalid)
		else $error("read not answered");

	a_read_quiet: assert property (@(posedge mclk) disable iff (!reset_n)
		!bus_req.rd |=> !rvalid && $stable(rdata))
		else $error("read answer or data change without a read");

	a_read_result_low_word: assert property (@(posedge mclk) disable iff (!reset_n)
		(bus_req.rd && bus_req.addr == PMAC_ADDR_RESULT_LOW_WORD) |=> rdata == $past(result_low_word_q))
		else $error("low result read wrong");

	a_read_op2: assert property (@(posedge mclk) disable iff (!reset_n)
		(bus_req.rd && bus_req.addr == PMAC_ADDR_OP2) |=> rdata == $past(op2_q))
		else $error("operand two read wrong");

	a_read_no_side: assert property (@(posedge mclk) disable iff (!reset_n)
		(bus_req.rd && !bus_req.wr && !start_q) |=> $stable(result_low_word_q) && $stable(result_high_word_q)
			&& $stable(sum_extension_word_q) && $stable(op1_q) && $stable(op2_q))
		else $error("read changed a register");

	// Informational only; the processor is never stalled by it.
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			busy <= 1'b0;
		end else begin
			busy <= wr_op2;
		end
	end

	// Named steps of one operation: the trigger write in a given mode, then the internal start.
	sequence s_launch;
		wr_op2;
	endsequence
	sequence s_launch_umul;
		wr_op2 && mode_q == PMAC_UMUL;
	endsequence
	sequence s_launch_uacc;
		wr_op2 && mode_q == PMAC_UACC;
	endsequence
	sequence s_launch_sacc;
		wr_op2 && mode_q == PMAC_SACC;
	endsequence
	sequence s_start_step;
		##1 start_q;
	endsequence

	// Busy marks the one cycle in which the operation is formed, and only that cycle.
	a_busy_pulse: assert property (@(posedge mclk) disable iff (!reset_n)
		s_launch |=> busy)
		else $error("busy missing after operand two");

	a_busy_idle: assert property (@(posedge mclk) disable iff (!reset_n)
		!wr_op2 |=> !busy)
		else $error("busy without operand two");

	// Reset leaves every register known, although software should not rely on the results.
	a_reset_state: assert property (@(posedge mclk)
		!reset_n |=> result_low_word_q == PMAC_RESET_WORD && result_high_word_q == PMAC_RESET_WORD && sum_extension_word_q == PMAC_RESET_WORD
			&& op1_q == PMAC_RESET_WORD && op2_q == PMAC_RESET_WORD && !rvalid && !busy && !start_q)
		else $error("registers not cleared by reset");

	// Result registers change only on the second edge after an operand-two write, or on the edge of a direct write.
	a_op1_no_start: assert property (@(posedge mclk) disable iff (!reset_n)
		(wr_op1 && !wr_op2) |=> !start_q)
		else $error("operand one write started an operation");

	a_result_timely: assert property (@(posedge mclk) disable iff (!reset_n)
		s_launch |-> s_start_step ##1 1'b1)
		else $error("result not updated in time");

	a_umul_sum_extension_word: assert property (@(posedge mclk) disable iff (!reset_n)
		(start_q && mode_q == PMAC_UMUL) |=> sum_extension_word_q == PMAC_RESET_WORD)
		else $error("sum extension not zero after unsigned multiply");

	a_smul_value: assert property (@(posedge mclk) disable iff (!reset_n)
		(start_q && mode_q == PMAC_SMUL) |=>
		{result_high_word_q, result_low_word_q} == 32'($signed($past(op1_q)) * $signed($past(op2_q))))
		else $error("signed product wrong");

	a_umul_value: assert property (@(posedge mclk) disable iff (!reset_n)
		(start_q && mode_q == PMAC_UMUL) |=> {result_high_word_q, result_low_word_q} == 32'($past(op1_q) * $past(op2_q)))
		else $error("unsigned product wrong");

	a_uacc_carry: assert property (@(posedge mclk) disable iff (!reset_n)
		(start_q && mode_q == PMAC_UACC) |=> sum_extension_word_q == {15'h0000, $past(acc_sum[32])})
		else $error("carry not reported");

	a_sign_ext: assert property (@(posedge mclk) disable iff (!reset_n)
		(start_q && signed_mode) |=> sum_extension_word_q == {16{result_high_word_q[15]}})
		else $error("sign extension wrong");

	a_op1_keeps: assert property (@(posedge mclk) disable iff (!reset_n)
		(!wr_op1) |=> op1_q == $past(op1_q) && mode_q == $past(mode_q))
		else $error("operand one changed without a write");

	a_byte_signext: assert property (@(posedge mclk) disable iff (!reset_n)
		(wr_op2 && bus_req.byte_acc && signed_mode) |=> op2_q[15:8] == {8{op2_q[7]}})
		else $error("signed byte not extended");

	// Each operand-one alias latches the operand and its own mode on the next edge.
	a_mode_umul: assert property (@(posedge mclk) disable iff (!reset_n)
		(bus_req.wr && bus_req.addr == PMAC_ADDR_OP1_UMUL) |=> mode_q == PMAC_UMUL)
		else $error("unsigned multiply mode not selected");

	a_mode_smul: assert property (@(posedge mclk) disable iff (!reset_n)
		(bus_req.wr && bus_req.addr == PMAC_ADDR_OP1_SMUL) |=> mode_q == PMAC_SMUL)
		else $error("signed multiply mode not selected");

	a_mode_uacc: assert property (@(posedge mclk) disable iff (!reset_n)
		(bus_req.wr && bus_req.addr == PMAC_ADDR_OP1_UACC) |=> mode_q == PMAC_UACC)
		else $error("unsigned accumulate mode not selected");

	a_mode_sacc: assert property (@(posedge mclk) disable iff (!reset_n)
		(bus_req.wr && bus_req.addr == PMAC_ADDR_OP1_SACC) |=> mode_q == PMAC_SACC)
		else $error("signed accumulate mode not selected");

	a_op1_word: assert property (@(posedge mclk) disable iff (!reset_n)
		(wr_op1 && !bus_req.byte_acc) |=> op1_q == $past(bus_req.wdata))
		else $error("operand one word not latched");

	// Byte operands are zero-filled at the unsigned aliases and sign-filled at the signed ones.
	a_op1_byte_zero: assert property (@(posedge mclk) disable iff (!reset_n)
		(bus_req.wr && bus_req.byte_acc
			&& (bus_req.addr == PMAC_ADDR_OP1_UMUL || bus_req.addr == PMAC_ADDR_OP1_UACC))
		|=> op1_q == {8'h00, $past(bus_req.wdata[7:0])})
		else $error("unsigned byte operand not zero-filled");

	a_op1_byte_sign: assert property (@(posedge mclk) disable iff (!reset_n)
		(bus_req.wr && bus_req.byte_acc
			&& (bus_req.addr == PMAC_ADDR_OP1_SMUL || bus_req.addr == PMAC_ADDR_OP1_SACC))
		|=> op1_q == {{8{$past(bus_req.wdata[7])}}, $past(bus_req.wdata[7:0])})
		else $error("signed byte operand not sign-filled");

	a_op1_no_results: assert property (@(posedge mclk) disable iff (!reset_n)
		(wr_op1 && !start_q) |=> $stable(result_low_word_q) && $stable(result_high_word_q) && $stable(sum_extension_word_q))
		else $error("operand one write changed a result");

	a_op2_word: assert property (@(posedge mclk) disable iff (!reset_n)
		(wr_op2 && !bus_req.byte_acc) |=> op2_q == $past(bus_req.wdata))
		else $error("operand two word not latched");

	// The landing is checked against the written data two edges back, inside the three-cycle budget.
	a_umul_landing: assert property (@(posedge mclk) disable iff (!reset_n)
		s_launch_umul |-> ##2 {result_high_word_q, result_low_word_q} == 32'($past(op1_q, 2) * $past(wdata_ext, 2)))
		else $error("unsigned product late or wrong");

	a_uacc_value: assert property (@(posedge mclk) disable iff (!reset_n)
		s_launch_uacc |-> ##2 {sum_extension_word_q[0], result_high_word_q, result_low_word_q}
			== {1'b0, $past(result_high_word_q), $past(result_low_word_q)} + {1'b0, 32'($past(op1_q, 2) * $past(wdata_ext, 2))})
		else $error("unsigned accumulation wrong");

	a_sacc_value: assert property (@(posedge mclk) disable iff (!reset_n)
		s_launch_sacc |-> ##2 {result_high_word_q, result_low_word_q}
			== {$past(result_high_word_q), $past(result_low_word_q)} + 32'($signed($past(op1_q, 2)) * $signed($past(wdata_ext, 2))))
		else $error("signed accumulation wrong");

	a_direct_lo: assert property (@(posedge mclk) disable iff (!reset_n)
		(bus_req.wr && !bus_req.byte_acc && bus_req.addr == PMAC_ADDR_RESULT_LOW_WORD && !start_q)
		|=> result_low_word_q == $past(bus_req.wdata))
		else $error("direct low result write lost");

	a_sum_extension_word_ro: assert property (@(posedge mclk) disable iff (!reset_n)
		(bus_req.wr && bus_req.addr == PMAC_ADDR_SUM_EXTENSION_WORD && !start_q) |=> $stable(sum_extension_word_q))
		else $error("sum extension written by software");

endmodule : pmac_core

`default_nettype wire

// ===== hw/pmac_pkg.sv
package pmac_pkg;

	// Register byte addresses on the peripheral bus.
	localparam logic [8:0] PMAC_ADDR_OP1_UMUL = 9'h130;
	localparam logic [8:0] PMAC_ADDR_OP1_SMUL = 9'h132;
	localparam logic [8:0] PMAC_ADDR_OP1_UACC = 9'h134;
	localparam logic [8:0] PMAC_ADDR_OP1_SACC = 9'h136;
	localparam logic [8:0] PMAC_ADDR_OP2 = 9'h138;
	localparam logic [8:0] PMAC_ADDR_RESULT_LOW_WORD = 9'h13A;
	localparam logic [8:0] PMAC_ADDR_RESULT_HIGH_WORD = 9'h13C;
	localparam logic [8:0] PMAC_ADDR_SUM_EXTENSION_WORD = 9'h13E;

	// Widths and reset values.
	localparam int PMAC_ADDR_W = 9;
	localparam int PMAC_DATA_W = 16;
	localparam logic [15:0] PMAC_RESET_WORD = 16'h0000;
	localparam logic [15:0] PMAC_ALL_ONES = 16'hFFFF;
	localparam logic [15:0] PMAC_CARRY_ONE = 16'h0001;
	localparam int PMAC_BYTE_SIGN = 7;

	// Cycle budget from operand two write to settled result.
	localparam int PMAC_RESULT_CYCLES = 3;

	typedef enum logic [1:0] {
		PMAC_UMUL,
		PMAC_SMUL,
		PMAC_UACC,
		PMAC_SACC
	} pmac_mode_e;

	// One processor access to the peripheral space.
	typedef struct packed {
		logic wr;
		logic rd;
		logic byte_acc;
		logic [8:0] addr;
		logic [15:0] wdata;
	} pmac_req_s;

endpackage : pmac_pkg
